// file: hw/serial_flash_command_front_end.sv
// serial flash command front end: link shifter and command executor
`timescale 1ns/100ps
module serial_flash_command_front_end
    import flash_cmd_pkg::*;
#(
    parameter int PU_DELAY_CYCLES = PU_CYCLES,
    parameter int ERASE_TIME_CYCLES = ERASE_CYCLES,
    parameter int PROG_TIME_CYCLES = PROG_CYCLES,
    parameter bit SECTOR_64K = 1'b1
) (
    // system
    input wire logic ref_clk,
    input wire logic resetn,
    // link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    output logic [7:0] par_out,
    output logic par_oe,
    // pins
    input wire logic vcc_ok,
    input wire logic accel_hv,
    // state
    output logic in_sleep,
    output logic parallel_mode,
    output logic busy
);
    // *******************************************************************
    // shared decoding
    // *******************************************************************
    function automatic logic [3:0] read_len(input logic [7:0] op);
        case (op)
            READ_CMD, READ_MAKER_DEV_CMD: read_len = LEN_ADDR;
            FAST_READ_CMD: read_len = LEN_ADDR_DUMMY;
            WAKE_SIGNATURE_CMD: read_len = LEN_ADDR;
            READ_IDENT_CMD, STATUS_READ_CMD: read_len = LEN_OPCODE;
            default: read_len = 4'h0;
        endcase
    endfunction

    function automatic logic allowed(input logic [7:0] op,
                                     input dev_view_t v);
        allowed = v.ready;
        if (v.sleep && op != WAKE_SIGNATURE_CMD) begin
            allowed = 1'b0;
        end
        if (v.accel && op != STATUS_READ_CMD && op != PAGE_PROGRAM_CMD) begin
            allowed = 1'b0;
        end
        if (v.busy && op != STATUS_READ_CMD) begin
            allowed = 1'b0;
        end
    endfunction

    function automatic logic resp_phase(input frame_t f, input dev_view_t v);
        logic [3:0] len;
        len = read_len(f.opcode);
        resp_phase = len != 4'h0 && f.byte_cnt >= len && allowed(f.opcode, v);
    endfunction

    function automatic logic [3:0] sat_inc(input logic [3:0] c);
        sat_inc = (c == 4'hf) ? c : c + 4'h1;
    endfunction

    // *******************************************************************
    // state
    // *******************************************************************
    ctrl_t ctl, next_ctl;
    frame_t frame, next_frame;
    out_t out, next_out;
    dev_view_t dv, view1, view2;
    logic fresh;
    logic cs_rise, cmd_fire, cmd_ok;
    logic [7:0] op;
    logic [3:0] nbytes;
    logic write_in_progress;

    assign write_in_progress = ctl.eng != ENG_IDLE;
    assign dv = '{ready: ctl.ready, sleep: ctl.sleep,
                  parallel: ctl.parallel, accel: ctl.accel, busy: write_in_progress,
                  status: {ctl.sr_hi, ctl.write_enable_latch, write_in_progress}};
    assign op = frame.opcode;
    assign nbytes = frame.byte_cnt;
    assign cs_rise = ctl.cs2 && !ctl.cs_prev;
    assign cmd_fire = cs_rise && frame.tag != ctl.seen_tag &&
                      frame.bit_cnt == 3'h0 && nbytes != 4'h0;
    assign cmd_ok = cmd_fire && ctl.vcc2 && allowed(op, dv);

    // *******************************************************************
    // link side: frame start flag
    // *******************************************************************
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // device state into the link domain
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            view1 <= '0;
            view2 <= '0;
        end else begin
            view1 <= dv;
            view2 <= view1;
        end
    end

    // *******************************************************************
    // link side: input shifter on rising edge
    // *******************************************************************
    always_comb begin
        frame_t cur;
        cur = frame;
        if (fresh) begin
            cur.bit_cnt = 3'h0;
            cur.byte_cnt = 4'h0;
            cur.resp_par = 1'b0;
            cur.tag = ~frame.tag;
        end
        next_frame = cur;
        if (resp_phase(cur, view2) && view2.parallel) begin
            next_frame.byte_cnt = sat_inc(cur.byte_cnt);
            next_frame.resp_par = ~cur.resp_par;
        end else begin
            next_frame.sh = {cur.sh[6:0], si};
            next_frame.bit_cnt = cur.bit_cnt + 3'h1;
            if (cur.bit_cnt == 3'h7) begin
                if (cur.byte_cnt == 4'h0) begin
                    next_frame.opcode = {cur.sh[6:0], si};
                end
                if (cur.byte_cnt == 4'h1) begin
                    next_frame.wdata = {cur.sh[6:0], si};
                end
                next_frame.byte_cnt = sat_inc(cur.byte_cnt);
                if (resp_phase(cur, view2)) begin
                    next_frame.resp_par = ~cur.resp_par;
                end
            end
        end
    end

    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    // *******************************************************************
    // link side: answer byte and output on falling edge
    // *******************************************************************
    function automatic logic [7:0] resp_byte(input frame_t f,
                                             input dev_view_t v);
        logic [3:0] k;
        k = f.byte_cnt - LEN_OPCODE;
        case (f.opcode)
            STATUS_READ_CMD: resp_byte = v.status;
            WAKE_SIGNATURE_CMD: resp_byte = SIGNATURE_CODE;
            READ_MAKER_DEV_CMD: begin
                resp_byte = f.resp_par ? TYPE_CODE : MAKER_CODE;
            end
            READ_IDENT_CMD: begin
                if (k == 4'h0) begin
                    resp_byte = MAKER_CODE;
                end else if (k == 4'h1) begin
                    resp_byte = TYPE_CODE;
                end else begin
                    resp_byte = CAPACITY_CODE;
                end
            end
            default: resp_byte = ARRAY_FILL;
        endcase
    endfunction

    always_comb begin
        logic more;
        logic [7:0] rb;
        more = !(op == READ_IDENT_CMD &&
                 frame.byte_cnt >= LEN_OPCODE + IDENT_BYTES);
        rb = resp_byte(frame, view2);
        next_out = out;
        next_out.par = view2.parallel;
        if (resp_phase(frame, view2) && more) begin
            next_out.drive = 1'b1;
            if (view2.parallel) begin
                next_out.pbyte = rb;
            end else if (frame.bit_cnt == 3'h0) begin
                next_out.tx = rb;
            end else begin
                next_out.tx = {out.tx[6:0], 1'b0};
            end
        end else begin
            next_out.drive = 1'b0;
        end
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            out <= '0;
        end else begin
            out <= next_out;
        end
    end

    assign so_out = out.tx[7];
    assign so_oe = out.drive && !out.par;
    assign par_out = out.pbyte;
    assign par_oe = out.drive && out.par;

    // *******************************************************************
    // core side: power, acceleration, engine and command execution
    // *******************************************************************
    always_comb begin
        next_ctl = ctl;
        next_ctl.cs1 = cs_n;
        next_ctl.cs2 = ctl.cs1;
        next_ctl.cs_prev = ctl.cs2;
        next_ctl.vcc1 = vcc_ok;
        next_ctl.vcc2 = ctl.vcc1;
        next_ctl.acc1 = accel_hv;
        next_ctl.acc2 = ctl.acc1;
        if (cs_rise) begin
            next_ctl.seen_tag = frame.tag;
        end
        // acceleration level follows the pin after the settle time
        if (ctl.acc2 == ctl.accel) begin
            next_ctl.acc_cnt = 4'h0;
        end else if (ctl.acc_cnt == 4'(SETTLE_CYCLES - 1)) begin
            next_ctl.accel = ctl.acc2;
            next_ctl.acc_cnt = 4'h0;
        end else begin
            next_ctl.acc_cnt = ctl.acc_cnt + 4'h1;
        end
        // embedded operation timer
        unique case (ctl.eng)
            ENG_IDLE: begin
            end
            ENG_ERASE, ENG_PROG: begin
                if (ctl.op_cnt == 16'h0) begin
                    next_ctl.eng = ENG_IDLE;
                    next_ctl.write_enable_latch = 1'b0;
                end else begin
                    next_ctl.op_cnt = ctl.op_cnt - 16'h1;
                end
            end
        endcase
        if (cmd_ok) begin
            case (op)
                WRITE_ENABLE_CMD: begin
                    if (nbytes == LEN_OPCODE) next_ctl.write_enable_latch = 1'b1;
                end
                WRITE_DISABLE_CMD: begin
                    if (nbytes == LEN_OPCODE) next_ctl.write_enable_latch = 1'b0;
                end
                SECTOR_ERASE_CMD, SECTOR_ERASE_ALT_CMD: begin
                    if (nbytes == LEN_ADDR && ctl.write_enable_latch &&
                        (op == SECTOR_ERASE_CMD || SECTOR_64K)) begin
                        next_ctl.eng = ENG_ERASE;
                        next_ctl.op_cnt = 16'(ERASE_TIME_CYCLES - 1);
                    end
                end
                WHOLE_ERASE_CMD, WHOLE_ERASE_ALT_CMD: begin
                    if (nbytes == LEN_OPCODE && ctl.write_enable_latch &&
                        (op == WHOLE_ERASE_CMD || SECTOR_64K)) begin
                        next_ctl.eng = ENG_ERASE;
                        next_ctl.op_cnt = 16'(ERASE_TIME_CYCLES - 1);
                    end
                end
                PAGE_PROGRAM_CMD: begin
                    if (nbytes >= LEN_ADDR_DUMMY && ctl.write_enable_latch) begin
                        next_ctl.eng = ENG_PROG;
                        next_ctl.op_cnt = 16'(PROG_TIME_CYCLES - 1);
                    end
                end
                STATUS_WRITE_CMD: begin
                    if (nbytes == LEN_STATUS_WRITE) begin
                        next_ctl.sr_hi = frame.wdata[7:2];
                    end
                end
                PARALLEL_ENTER_CMD: begin
                    if (nbytes == LEN_OPCODE) next_ctl.parallel = 1'b1;
                end
                PARALLEL_EXIT_CMD: begin
                    if (nbytes == LEN_OPCODE) next_ctl.parallel = 1'b0;
                end
                SLEEP_CMD: begin
                    if (nbytes == LEN_OPCODE) next_ctl.sleep = 1'b1;
                end
                WAKE_SIGNATURE_CMD: begin
                    next_ctl.sleep = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // supply loss and power-up delay
        if (!ctl.vcc2) begin
            next_ctl.ready = 1'b0;
            next_ctl.pu_cnt = 14'h0;
            next_ctl.sleep = 1'b0;
            next_ctl.write_enable_latch = 1'b0;
            next_ctl.parallel = 1'b0;
            next_ctl.eng = ENG_IDLE;
        end else if (!ctl.ready) begin
            if (ctl.pu_cnt == 14'(PU_DELAY_CYCLES - 1)) begin
                next_ctl.ready = 1'b1;
            end else begin
                next_ctl.pu_cnt = ctl.pu_cnt + 14'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctl <= '0;
        end else begin
            ctl <= next_ctl;
        end
    end

    assign in_sleep = ctl.sleep;
    assign parallel_mode = ctl.parallel;
    assign busy = write_in_progress;

    // *******************************************************************
    // checks
    // *******************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_exec(logic [7:0] code, logic [3:0] len);
        cmd_ok && op == code && nbytes == len;
    endsequence
    sequence s_erase_go;
        cmd_ok && nbytes == LEN_ADDR && ctl.write_enable_latch && !write_in_progress && ctl.vcc2 &&
        (op == SECTOR_ERASE_CMD || (SECTOR_64K && op == SECTOR_ERASE_ALT_CMD));
    endsequence

    a_wel_set: assert property (
        s_exec(WRITE_ENABLE_CMD, LEN_OPCODE) |=> ctl.write_enable_latch)
        else $error("write enable did not set latch");
    a_wel_clear: assert property (
        s_exec(WRITE_DISABLE_CMD, LEN_OPCODE) |=> !ctl.write_enable_latch)
        else $error("write disable did not clear latch");
    a_sleep_enter: assert property (
        s_exec(SLEEP_CMD, LEN_OPCODE) ##1 ctl.vcc2 |-> ctl.sleep)
        else $error("sleep command ignored");
    a_wake_exit: assert property (
        cmd_ok && op == WAKE_SIGNATURE_CMD |=> !ctl.sleep)
        else $error("wake command did not leave sleep");
    a_sleep_hold: assert property (
        ctl.sleep && ctl.vcc2 && cmd_fire && op != WAKE_SIGNATURE_CMD
        |=> ctl.sleep && $stable(ctl.write_enable_latch) && $stable(ctl.parallel))
        else $error("command acted during sleep");
    a_accel_gate: assert property (
        ctl.accel && cmd_fire && op != STATUS_READ_CMD &&
        op != PAGE_PROGRAM_CMD |=> $stable(ctl.write_enable_latch) && $stable(ctl.sr_hi))
        else $error("command acted under acceleration voltage");
    a_erase_wip: assert property (
        s_erase_go |=> write_in_progress ##1 dv.status[0])
        else $error("erase did not raise write in progress");
    a_erase_done: assert property (
        $fell(write_in_progress) |-> !ctl.write_enable_latch && dv.status[0] == 1'b0)
        else $error("erase end left latch set");
    a_power_loss: assert property (
        !ctl.vcc2 |=> !ctl.ready && !ctl.sleep && !ctl.write_enable_latch && !write_in_progress)
        else $error("state kept through supply loss");
    a_status_write: assert property (
        s_exec(STATUS_WRITE_CMD, LEN_STATUS_WRITE) ##1 ctl.vcc2
        |-> ctl.sr_hi == $past(frame.wdata[7:2], 1))
        else $error("status write lost");
    a_par_enter: assert property (
        s_exec(PARALLEL_ENTER_CMD, LEN_OPCODE) ##1 ctl.vcc2 |-> ctl.parallel)
        else $error("parallel mode not entered");
endmodule // serial_flash_command_front_end

// file: pkg/flash_cmd_pkg.sv
// constants, opcodes and carrier types of the serial flash command front end
package flash_cmd_pkg;
    // *******************************************************************
    // timing
    // *******************************************************************
    localparam int CLK_NS = 20;
    localparam int PU_DELAY_US = 300;
    localparam int PU_CYCLES = (PU_DELAY_US * 1000) / CLK_NS;
    localparam int SETTLE_NS = 5;
    localparam int SETTLE_RAW = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
    localparam int ERASE_CYCLES = 64;
    localparam int PROG_CYCLES = 16;
    // *******************************************************************
    // opcodes
    // *******************************************************************
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] FAST_READ_CMD = 8'h0b;
    localparam logic [7:0] READ_IDENT_CMD = 8'h9f;
    localparam logic [7:0] READ_MAKER_DEV_CMD = 8'h90;
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hd8;
    localparam logic [7:0] SECTOR_ERASE_ALT_CMD = 8'h20;
    localparam logic [7:0] WHOLE_ERASE_CMD = 8'hc7;
    localparam logic [7:0] WHOLE_ERASE_ALT_CMD = 8'h60;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] PARALLEL_ENTER_CMD = 8'h55;
    localparam logic [7:0] PARALLEL_EXIT_CMD = 8'h45;
    localparam logic [7:0] SLEEP_CMD = 8'hb9;
    localparam logic [7:0] WAKE_SIGNATURE_CMD = 8'hab;
    // *******************************************************************
    // frame lengths in bytes, opcode included; IDENT_BYTES counts answer bytes only
    // *******************************************************************
    localparam logic [3:0] LEN_OPCODE = 4'h1;
    localparam logic [3:0] LEN_ADDR = 4'h4;
    localparam logic [3:0] LEN_ADDR_DUMMY = 4'h5;
    localparam logic [3:0] LEN_STATUS_WRITE = 4'h2;
    localparam logic [3:0] IDENT_BYTES = 4'h3;
    // *******************************************************************
    // data values; identification values are arbitrary
    // *******************************************************************
    localparam logic [7:0] ARRAY_FILL = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MAKER_CODE = 8'h5a;
    localparam logic [7:0] TYPE_CODE = 8'h3c;
    localparam logic [7:0] CAPACITY_CODE = 8'h18;
    localparam logic [7:0] SIGNATURE_CODE = 8'h17;
    // *******************************************************************
    // carrier types
    // *******************************************************************
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_ERASE = 2'b01,
        ENG_PROG = 2'b11
    } eng_t;
    typedef struct packed {
        logic ready;
        logic sleep;
        logic parallel;
        logic accel;
        logic busy;
        logic [7:0] status;
    } dev_view_t;
    typedef struct packed {
        logic tag;
        logic [2:0] bit_cnt;
        logic [3:0] byte_cnt;
        logic [7:0] sh;
        logic [7:0] opcode;
        logic [7:0] wdata;
        logic resp_par;
    } frame_t;
    typedef struct packed {
        logic drive;
        logic par;
        logic [7:0] tx;
        logic [7:0] pbyte;
    } out_t;
    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs_prev;
        logic vcc1;
        logic vcc2;
        logic acc1;
        logic acc2;
        logic ready;
        logic accel;
        logic sleep;
        logic parallel;
        logic write_enable_latch;
        logic seen_tag;
        logic [3:0] acc_cnt;
        logic [13:0] pu_cnt;
        logic [15:0] op_cnt;
        logic [5:0] sr_hi;
        eng_t eng;
    } ctrl_t;
endpackage

// file: sim/flash_host_model.sv
// host link model: select, link clock and serial input, answer capture
`timescale 1ns/100ps
module flash_host_model (
    // link
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic [7:0] par_out,
    input wire logic par_oe
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // n header bytes from the top of hdr, then m answer bytes
    task automatic frame(input logic [39:0] hdr, input int n, input int m,
                         input bit par, output logic [23:0] rd,
                         output logic seen);
        rd = 24'h0;
        seen = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            si = hdr[39 - i];
            #62.5 sck = 1'b1;
            #62.5 sck = 1'b0;
        end
        for (int i = 0; i < m * (par ? 1 : 8); i++) begin
            // input is don't care here, so it keeps toggling
            si = ~si;
            #62.5;
            seen |= par ? par_oe : so_oe;
            rd = par ? {rd[15:0], par_out} : {rd[22:0], so_out};
            sck = 1'b1;
            #62.5 sck = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        // select gap and execution time
        #500;
    endtask
endmodule // flash_host_model

// file: sim/serial_flash_command_front_end_test.sv
// self-checking bench of the serial flash command front end
`timescale 1ns/100ps
module serial_flash_command_front_end_test;
    import flash_cmd_pkg::*;
    localparam int PU = 8;
    localparam logic [7:0] ER [4] = '{8'h20, 8'hd8, 8'hc7, 8'h60};
    logic ref_clk, resetn, vcc_ok, accel_hv, sck, cs_n, si, so_out, so_oe;
    logic par_oe, in_sleep, parallel_mode, busy, seen;
    logic [7:0] par_out;
    logic [23:0] rd;
    int errors = 0;
    int samples_checked = 0;
    serial_flash_command_front_end #(.PU_DELAY_CYCLES(PU),
        .ERASE_TIME_CYCLES(400), .PROG_TIME_CYCLES(100))
        serial_flash_command_front_end_i (.ref_clk(ref_clk),
        .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
        .so_oe(so_oe), .par_out(par_out), .par_oe(par_oe), .vcc_ok(vcc_ok),
        .accel_hv(accel_hv), .in_sleep(in_sleep),
        .parallel_mode(parallel_mode), .busy(busy));
    flash_host_model flash_host_model_i (.sck(sck), .cs_n(cs_n), .si(si),
        .so_out(so_out), .so_oe(so_oe), .par_out(par_out), .par_oe(par_oe));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic run(logic [7:0] op, logic [31:0] t, int n, int m, bit p);
        flash_host_model_i.frame({op, t}, n, m, p, rd, seen);
    endtask
    task automatic st(input logic [7:0] e);
        run(STATUS_READ_CMD, 32'h0, 1, 2, 1'b0);
        chk({seen, rd[15:0]}, {1'b1, e, e});
    endtask
    task automatic drive_pin(input bit hv, input bit ok);
        @(posedge ref_clk);
        #1 accel_hv = hv;
        vcc_ok = ok;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic reset_dut;
        @(posedge ref_clk);
        #1 resetn = 1'b0;
        vcc_ok = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 resetn = 1'b1;
        repeat (PU + 20) @(posedge ref_clk);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 2000; i++) begin
            @(posedge ref_clk);
            #1;
            if (busy === 1'b0) return;
        end
        chk(busy, 0);
        results();
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        vcc_ok = 1'b1;
        accel_hv = 1'b0;
        reset_dut();
        chk({in_sleep, parallel_mode, busy}, 0);
        st(STATUS_RESET);
        run(READ_CMD, 32'h0, 4, 2, 1'b0);
        chk(rd[15:0], 16'hffff);
        run(FAST_READ_CMD, 32'h0, 5, 1, 1'b0);
        chk({seen, rd[7:0]}, {1'b1, 8'hff});
        run(READ_IDENT_CMD, 32'h0, 1, 3, 1'b0);
        chk(rd, {MAKER_CODE, TYPE_CODE, CAPACITY_CODE});
        run(READ_MAKER_DEV_CMD, 32'h0, 4, 2, 1'b0);
        chk(rd[15:0], {MAKER_CODE, TYPE_CODE});
        $display("reads done");
        run(STATUS_WRITE_CMD, 32'hfc000000, 2, 0, 1'b0);
        st(8'hfc);
        run(STATUS_WRITE_CMD, 32'h0, 3, 0, 1'b0);
        st(8'hfc);
        run(STATUS_WRITE_CMD, 32'h0, 2, 0, 1'b0);
        run(WRITE_ENABLE_CMD, 32'h0, 1, 0, 1'b0);
        st(8'h02);
        run(WRITE_DISABLE_CMD, 32'h0, 1, 0, 1'b0);
        st(8'h00);
        $display("status done");
        run(SECTOR_ERASE_ALT_CMD, 32'h0, 4, 0, 1'b0);
        chk(busy, 0);
        for (int i = 0; i < 4; i++) begin
            run(WRITE_ENABLE_CMD, 32'h0, 1, 0, 1'b0);
            run(ER[i], 32'h0, (i < 2) ? 4 : 1, 0, 1'b0);
            chk(busy, 1);
            run(STATUS_READ_CMD, 32'h0, 1, 1, 1'b0);
            chk(rd[0], 1);
            wait_idle();
            run(STATUS_READ_CMD, 32'h0, 1, 1, 1'b0);
            chk(rd[0], 0);
        end
        run(WRITE_ENABLE_CMD, 32'h0, 1, 0, 1'b0);
        run(PAGE_PROGRAM_CMD, 32'h0, 5, 0, 1'b0);
        chk(busy, 1);
        wait_idle();
        $display("erase and program done");
        drive_pin(1'b1, 1'b1);
        run(WRITE_ENABLE_CMD, 32'h0, 1, 0, 1'b0);
        st(8'h00);
        run(READ_IDENT_CMD, 32'h0, 1, 1, 1'b0);
        chk(seen, 0);
        drive_pin(1'b0, 1'b1);
        run(WRITE_ENABLE_CMD, 32'h0, 1, 0, 1'b0);
        st(8'h02);
        run(WRITE_DISABLE_CMD, 32'h0, 1, 0, 1'b0);
        $display("acceleration done");
        run(PARALLEL_ENTER_CMD, 32'h0, 1, 0, 1'b0);
        chk(parallel_mode, 1);
        run(READ_IDENT_CMD, 32'h0, 1, 3, 1'b1);
        chk({seen, rd}, {1'b1, MAKER_CODE, TYPE_CODE, CAPACITY_CODE});
        run(PARALLEL_EXIT_CMD, 32'h0, 1, 0, 1'b0);
        chk(parallel_mode, 0);
        st(8'h00);
        $display("parallel done");
        run(SLEEP_CMD, 32'h0, 1, 0, 1'b0);
        chk(in_sleep, 1);
        run(STATUS_READ_CMD, 32'h0, 1, 1, 1'b0);
        chk(seen, 0);
        run(WRITE_ENABLE_CMD, 32'h0, 1, 0, 1'b0);
        run(WAKE_SIGNATURE_CMD, 32'h0, 1, 0, 1'b0);
        chk(in_sleep, 0);
        st(8'h00);
        run(SLEEP_CMD, 32'h0, 1, 0, 1'b0);
        run(WAKE_SIGNATURE_CMD, 32'h0, 4, 2, 1'b0);
        chk({in_sleep, seen, rd[15:0]},
            {2'b01, SIGNATURE_CODE, SIGNATURE_CODE});
        $display("sleep done");
        run(WRITE_ENABLE_CMD, 32'h0, 1, 0, 1'b0);
        drive_pin(1'b0, 1'b0);
        run(STATUS_READ_CMD, 32'h0, 1, 1, 1'b0);
        chk(seen, 0);
        reset_dut();
        st(8'h00);
        $display("power done");
        results();
    end
endmodule // serial_flash_command_front_end_test
